// file: ifd_map.vh
`ifndef IFD_MAP_VH
`define IFD_MAP_VH

// ****************************************************************
// stream geometry
// ****************************************************************
`define IFD_NUM_INST      5
`define IFD_NUM_DEC       4
`define IFD_CLASS_W       3
`define IFD_FORM_W        3
`define IFD_COND_W        4
`define IFD_IDX_W         3
`define IFD_CNT_W         2

// ****************************************************************
// instruction classes from predecode
// ****************************************************************
`define IFD_CLS_ALU       3'h0
`define IFD_CLS_CMP       3'h1
`define IFD_CLS_TEST      3'h2
`define IFD_CLS_STORE     3'h3
`define IFD_CLS_LDJMP     3'h4
`define IFD_CLS_RETURN    3'h5
`define IFD_CLS_JCC       3'h6
`define IFD_CLS_OTHER     3'h7

// ****************************************************************
// operand forms (first operand first)
// ****************************************************************
`define IFD_FORM_RR       3'h0
`define IFD_FORM_RI       3'h1
`define IFD_FORM_RM       3'h2
`define IFD_FORM_MR       3'h3
`define IFD_FORM_MI       3'h4
`define IFD_FORM_M        3'h5
`define IFD_FORM_NONE     3'h6

// ****************************************************************
// branch condition codes
// ****************************************************************
`define IFD_CC_BELOW      4'h2
`define IFD_CC_NOT_BELOW  4'h3
`define IFD_CC_EQUAL      4'h4
`define IFD_CC_NOT_EQUAL  4'h5
`define IFD_CC_BELOW_EQ   4'h6
`define IFD_CC_ABOVE      4'h7

// ****************************************************************
// reset values
// ****************************************************************
`define IFD_RST_VALID     4'h0
`define IFD_RST_CNT       2'h0
`define IFD_RST_CLS       3'h0
`define IFD_RST_CC        4'h0
`define IFD_RST_IDX       3'h0
`define IFD_RST_FLAGS     4'h0

`endif

// file: ifd_decoder.v
`timescale 1ns/100ps
`include "ifd_map.vh"

module ifd_decoder (
	input  wire        mclk_in,
	input  wire        rst_n_in,
	input  wire        mode64_in,
	input  wire [4:0]  inst_valid_in,
	input  wire [14:0] inst_class_in,
	input  wire [14:0] inst_form_in,
	input  wire [19:0] inst_cond_in,
	input  wire [4:0]  inst_iprel_in,
	input  wire        uop_ready_in,
	output wire [2:0]  take_count_out,
	output reg  [3:0]  uop_valid_out,
	output reg  [11:0] uop_class_out,
	output reg  [15:0] uop_cond_out,
	output reg  [11:0] uop_src_idx_out,
	output reg  [7:0]  uop_fused_cnt_out,
	output reg  [7:0]  uop_unfused_cnt_out,
	output reg  [3:0]  uop_micro_fused_out,
	output reg  [3:0]  uop_macro_fused_out
);

	// ****************************************************************
	// decode functions
	// ****************************************************************
	function has_mem;
		input [2:0] form;
		begin
			has_mem = (form == `IFD_FORM_RM) || (form == `IFD_FORM_MR) ||
				(form == `IFD_FORM_MI) || (form == `IFD_FORM_M);
		end
	endfunction

	// ip-relative memory access that cannot be micro-fused
	function iprel_split;
		input [2:0] cls;
		input [2:0] form;
		input       iprel;
		begin
			iprel_split = iprel && has_mem(form) &&
				((form == `IFD_FORM_MI) || (cls == `IFD_CLS_LDJMP));
		end
	endfunction

	// micro-ops as executed, before fusion
	function [1:0] unfused_cnt;
		input [2:0] cls;
		input [2:0] form;
		begin
			if (cls == `IFD_CLS_STORE) begin
				unfused_cnt = 2'h2;
			end else if (cls == `IFD_CLS_RETURN) begin
				unfused_cnt = 2'h2;
			end else if (has_mem(form)) begin
				unfused_cnt = 2'h2;
			end else begin
				unfused_cnt = 2'h1;
			end
		end
	endfunction

	// micro-fusion eligibility
	function micro_ok;
		input [2:0] cls;
		input [2:0] form;
		input       iprel;
		begin
			case (cls)
				`IFD_CLS_STORE:  micro_ok = 1'b1;
				`IFD_CLS_ALU:    micro_ok = has_mem(form);
				`IFD_CLS_LDJMP:  micro_ok = has_mem(form);
				`IFD_CLS_RETURN: micro_ok = 1'b1;
				`IFD_CLS_CMP:    micro_ok = has_mem(form);
				`IFD_CLS_TEST:   micro_ok = has_mem(form);
				default:         micro_ok = 1'b0;
			endcase
			if (iprel_split(cls, form, iprel))
				micro_ok = 1'b0;
		end
	endfunction

	// branch condition acceptable after the first instruction
	function cond_ok;
		input [2:0] cls;
		input [3:0] cc;
		begin
			if (cls == `IFD_CLS_TEST) begin
				cond_ok = 1'b1;
			end else begin
				// carry and zero flag conditions only
				case (cc)
					`IFD_CC_BELOW:     cond_ok = 1'b1;
					`IFD_CC_NOT_BELOW: cond_ok = 1'b1;
					`IFD_CC_EQUAL:     cond_ok = 1'b1;
					`IFD_CC_NOT_EQUAL: cond_ok = 1'b1;
					`IFD_CC_BELOW_EQ:  cond_ok = 1'b1;
					`IFD_CC_ABOVE:     cond_ok = 1'b1;
					default:           cond_ok = 1'b0;
				endcase
			end
		end
	endfunction

	// macro-fusion eligibility of a pair
	function pair_ok;
		input [2:0] cls_a;
		input [2:0] form_a;
		input       iprel_a;
		input [2:0] cls_b;
		input [3:0] cc_b;
		input       m64;
		reg         form_fit;
		begin
			form_fit = (form_a == `IFD_FORM_RR) ||
				(form_a == `IFD_FORM_RI) ||
				(form_a == `IFD_FORM_RM) || (form_a == `IFD_FORM_MR);
			pair_ok = ((cls_a == `IFD_CLS_CMP) || (cls_a == `IFD_CLS_TEST)) &&
				form_fit && !m64 && (cls_b == `IFD_CLS_JCC) &&
				!iprel_split(cls_a, form_a, iprel_a) &&
				cond_ok(cls_a, cc_b);
		end
	endfunction

	// fused-domain micro-ops of one decoder slot
	function [1:0] fused_cnt;
		input [2:0] cls;
		input [2:0] form;
		input       iprel;
		begin
			// split flow is two separate micro-ops
			if (micro_ok(cls, form, iprel))
				fused_cnt = 2'h1;
			else
				fused_cnt = unfused_cnt(cls, form);
		end
	endfunction

	// one 3-bit field of the per-slot class or form vector
	function [2:0] field3;
		input [14:0] vec;
		input integer i;
		begin
			field3 = vec[i*3 +: 3];
		end
	endfunction

	// one 4-bit condition field of the per-slot vector
	function [3:0] field4;
		input [19:0] vec;
		input integer i;
		begin
			field4 = vec[i*4 +: 4];
		end
	endfunction

	// ****************************************************************
	// slot allocation
	// ****************************************************************
	reg  [3:0]  valid_nxt;
	reg  [11:0] class_nxt;
	reg  [15:0] cond_nxt;
	reg  [11:0] idx_nxt;
	reg  [7:0]  fcnt_nxt;
	reg  [7:0]  ucnt_nxt;
	reg  [3:0]  micro_nxt;
	reg  [3:0]  macro_nxt;
	reg  [2:0]  take_nxt;
	reg  [2:0]  cls_p;
	reg  [2:0]  form_p;
	reg         iprel_p;
	reg         stop;
	reg         pair_used;
	reg         fuse;
	integer     p;
	integer     d;

	always @* begin
		valid_nxt = 4'h0;
		class_nxt = 12'h000;
		cond_nxt  = 16'h0000;
		idx_nxt   = 12'h000;
		fcnt_nxt  = 8'h00;
		ucnt_nxt  = 8'h00;
		micro_nxt = 4'h0;
		macro_nxt = 4'h0;
		cls_p     = 3'h0;
		form_p    = 3'h0;
		iprel_p   = 1'b0;
		stop      = 1'b0;
		pair_used = 1'b0;
		fuse      = 1'b0;
		p         = 0;
		// identical logic in every decoder slot, except that slot zero skips the split-flow stop
		for (d = 0; d < `IFD_NUM_DEC; d = d + 1) begin
			if (p >= `IFD_NUM_INST)
				stop = 1'b1;
			else if (!inst_valid_in[p])
				stop = 1'b1;
			if (!stop) begin
				cls_p   = field3(inst_class_in, p);
				form_p  = field3(inst_form_in, p);
				iprel_p = inst_iprel_in[p];
				// split flow waits for decoder zero
				if ((d != 0) && iprel_split(cls_p, form_p, iprel_p))
					stop = 1'b1;
			end
			if (!stop) begin
				fuse = 1'b0;
				if (!pair_used && (p < `IFD_NUM_INST - 1)) begin
					if (inst_valid_in[p+1])
						fuse = pair_ok(cls_p, form_p, iprel_p,
							field3(inst_class_in, p + 1),
							field4(inst_cond_in, p + 1), mode64_in);
				end
				valid_nxt[d]          = 1'b1;
				class_nxt[d*3 +: 3]   = cls_p;
				idx_nxt[d*3 +: 3]     = p[2:0];
				micro_nxt[d]          = micro_ok(cls_p, form_p, iprel_p);
				ucnt_nxt[d*2 +: 2]    = unfused_cnt(cls_p, form_p);
				fcnt_nxt[d*2 +: 2]    = fused_cnt(cls_p, form_p, iprel_p);
				if (fuse) begin
					macro_nxt[d]       = 1'b1;
					pair_used          = 1'b1;
					cond_nxt[d*4 +: 4] = field4(inst_cond_in, p + 1);
					p                  = p + 2;
				end else begin
					cond_nxt[d*4 +: 4] = field4(inst_cond_in, p);
					p                  = p + 1;
				end
			end
		end
		take_nxt = p[2:0];
	end

	// ****************************************************************
	// combinational take count and output registers
	// ****************************************************************
	// consumed instructions only while downstream accepts
	assign take_count_out = uop_ready_in ? take_nxt : 3'h0;

	always @(posedge mclk_in) begin
		if (!rst_n_in) begin
			uop_valid_out       <= `IFD_RST_VALID;
			uop_class_out       <= {4{`IFD_RST_CLS}};
			uop_cond_out        <= {4{`IFD_RST_CC}};
			uop_src_idx_out     <= {4{`IFD_RST_IDX}};
			uop_fused_cnt_out   <= {4{`IFD_RST_CNT}};
			uop_unfused_cnt_out <= {4{`IFD_RST_CNT}};
			uop_micro_fused_out <= `IFD_RST_FLAGS;
			uop_macro_fused_out <= `IFD_RST_FLAGS;
		end else if (uop_ready_in) begin
			uop_valid_out       <= valid_nxt;
			uop_class_out       <= class_nxt;
			uop_cond_out        <= cond_nxt;
			uop_src_idx_out     <= idx_nxt;
			uop_fused_cnt_out   <= fcnt_nxt;
			uop_unfused_cnt_out <= ucnt_nxt;
			uop_micro_fused_out <= micro_nxt;
			uop_macro_fused_out <= macro_nxt;
		end
	end

endmodule // ifd_decoder

// file: ifd_decoder_assertions.sv
`timescale 1ns/100ps
module ifd_decoder_assertions (
	input logic        mclk_in,
	input logic        rst_n_in,
	input logic        mode64_in,
	input logic [4:0]  inst_valid_in,
	input logic [14:0] inst_class_in,
	input logic [14:0] inst_form_in,
	input logic [19:0] inst_cond_in,
	input logic [4:0]  inst_iprel_in,
	input logic        uop_ready_in,
	input logic [2:0]  take_count_out,
	input logic [3:0]  uop_valid_out,
	input logic [11:0] uop_class_out,
	input logic [15:0] uop_cond_out,
	input logic [11:0] uop_src_idx_out,
	input logic [7:0]  uop_fused_cnt_out,
	input logic [7:0]  uop_unfused_cnt_out,
	input logic [3:0]  uop_micro_fused_out,
	input logic [3:0]  uop_macro_fused_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_take64;
		uop_ready_in && mode64_in;
	endsequence
	property p_stall; !uop_ready_in |-> take_count_out == 3'h0; endproperty
	a_stall: assert property (p_stall) else $error("take while stalled");
	property p_take_max; take_count_out <= 3'h5; endproperty
	a_take_max: assert property (p_take_max) else $error("take above 5");
	property p_hold;
		!uop_ready_in |=> $stable(uop_valid_out) && $stable(uop_cond_out);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved");
	property p_no64; s_take64 |=> uop_macro_fused_out == 4'h0; endproperty
	a_no64: assert property (p_no64) else $error("pair in 64 mode");
	property p_pair_valid; (uop_macro_fused_out & ~uop_valid_out) == 4'h0;
	endproperty
	a_pair_valid: assert property (p_pair_valid) else $error("bad pair");
	property p_one_pair; $onehot0(uop_macro_fused_out); endproperty
	a_one_pair: assert property (p_one_pair) else $error("two pairs");
	property p_dec0;
		uop_fused_cnt_out[1:0] != 2'h3 &&
			!(uop_valid_out[1] && uop_class_out[5:3] < 3'h6 &&
			uop_fused_cnt_out[3:2] == 2'h2) &&
			!(uop_valid_out[2] && uop_class_out[8:6] < 3'h6 &&
			uop_fused_cnt_out[5:4] == 2'h2) &&
			!(uop_valid_out[3] && uop_class_out[11:9] < 3'h6 &&
			uop_fused_cnt_out[7:6] == 2'h2);
	endproperty
	a_dec0: assert property (p_dec0) else $error("split off slot 0");
	property p_micro_cnt;
		uop_micro_fused_out[0] && uop_valid_out[0] |->
			uop_fused_cnt_out[1:0] == 2'h1;
	endproperty
	a_micro_cnt: assert property (p_micro_cnt) else $error("fused cnt");
endmodule // ifd_decoder_assertions

bind ifd_decoder ifd_decoder_assertions ifd_decoder_assertions_i (
	.mclk_in, .rst_n_in, .mode64_in, .inst_valid_in, .inst_class_in,
	.inst_form_in, .inst_cond_in, .inst_iprel_in, .uop_ready_in,
	.take_count_out, .uop_valid_out, .uop_class_out, .uop_cond_out,
	.uop_src_idx_out, .uop_fused_cnt_out, .uop_unfused_cnt_out,
	.uop_micro_fused_out, .uop_macro_fused_out);

// file: ifd_sink_model.sv
`timescale 1ns/100ps
// rename stage: accepts every cycle, or every other cycle when slow
module ifd_sink_model (
	input  logic mclk_in,
	input  logic rst_n_in,
	input  logic slow_in,
	output logic uop_ready_out
);
	logic phase_r;
	always @(posedge mclk_in) begin
		phase_r <= rst_n_in ? ~phase_r : 1'b0;
		uop_ready_out <= ~slow_in | phase_r;
	end
endmodule // ifd_sink_model

// file: test_instruction_fusion_decoder.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
module test_instruction_fusion_decoder;
	logic        mclk_in = 0, rst_n_in = 0, mode64_in = 0, slow = 0;
	logic [4:0]  inst_valid_in = 0, inst_iprel_in = 0;
	logic [14:0] inst_class_in = 0, inst_form_in = 0;
	logic [19:0] inst_cond_in = 0;
	logic        uop_ready_in;
	logic [2:0]  take_count_out;
	logic [3:0]  uop_valid_out, uop_micro_fused_out, uop_macro_fused_out;
	logic [11:0] uop_class_out, uop_src_idx_out;
	logic [15:0] uop_cond_out;
	logic [7:0]  uop_fused_cnt_out, uop_unfused_cnt_out;
	int          err_count = 0, n_tests = 0, cycles = 0;
	always #5 mclk_in = ~mclk_in;
	ifd_sink_model ifd_sink_model_i (.mclk_in, .rst_n_in, .slow_in(slow),
		.uop_ready_out(uop_ready_in));
	ifd_decoder ifd_decoder_i (.mclk_in, .rst_n_in, .mode64_in,
		.inst_valid_in, .inst_class_in, .inst_form_in, .inst_cond_in,
		.inst_iprel_in, .uop_ready_in, .take_count_out, .uop_valid_out,
		.uop_class_out, .uop_cond_out, .uop_src_idx_out,
		.uop_fused_cnt_out, .uop_unfused_cnt_out, .uop_micro_fused_out,
		.uop_macro_fused_out);
	task print_verdict;
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			print_verdict;
		end
	end
	// one group presented for one taken edge
	task step(input [14:0] c, f, input [19:0] cc, input [4:0] ip, v,
		input [2:0] tk);
		@(posedge mclk_in);
		inst_class_in <= c;
		inst_form_in <= f;
		inst_cond_in <= cc;
		inst_iprel_in <= ip;
		inst_valid_in <= v;
		#1;
		`CHK("take", tk, take_count_out)
		@(posedge mclk_in);
		#1;
	endtask
	task t_walk;
		step(15'h0031, 15'h0, 20'h40, 5'h0, 5'h1f, 3'h5);
		`CHK("valid", 4'hf, uop_valid_out)
		`CHK("pair", 4'h1, uop_macro_fused_out)
		`CHK("cond", 4'h4, uop_cond_out[3:0])
		`CHK("src", 12'h8d0, uop_src_idx_out)
		`CHK("unf", 6'h15, uop_unfused_cnt_out[7:2])
	endtask
	task t_cc;
		logic fuse;
		for (int k = 0; k < 16; k++) begin
			fuse = k[3] || k[2:0] >= 2;
			step({9'h0, 3'h6, 1'b0, k[3], ~k[3]}, 15'h0,
				{13'h0, k[2:0], 4'h0}, 5'h0, 5'h03, 3'h2);
			`CHK("pair", {3'h0, fuse}, uop_macro_fused_out)
			`CHK("valid", {2'h0, ~fuse, 1'b1}, uop_valid_out)
		end
	endtask
	task t_no_pair;
		step(15'h0031, 15'h0004, 20'h40, 5'h0, 5'h03, 3'h2);
		`CHK("pair", 4'h0, uop_macro_fused_out)
		`CHK("micro", 1'b1, uop_micro_fused_out[0])
		@(posedge mclk_in);
		mode64_in <= 1'b1;
		step(15'h0031, 15'h0003, 20'h40, 5'h0, 5'h03, 3'h2);
		`CHK("pair", 4'h0, uop_macro_fused_out)
		@(posedge mclk_in);
		mode64_in <= 1'b0;
		step(15'h0031, 15'h0003, 20'h40, 5'h0, 5'h03, 3'h2);
		`CHK("pair", 4'h1, uop_macro_fused_out)
	endtask
	task t_micro;
		step(15'h0b18, 15'h0d52, 20'h0, 5'h0, 5'h0f, 3'h4);
		`CHK("micro", 4'hf, uop_micro_fused_out)
		`CHK("class", 12'hb18, uop_class_out)
		`CHK("unf", 8'haa, uop_unfused_cnt_out)
		`CHK("fus", 8'h55, uop_fused_cnt_out)
	endtask
	task t_iprel;
		step(15'h0018, 15'h0020, 20'h0, 5'h02, 5'h03, 3'h1);
		`CHK("valid", 4'h1, uop_valid_out)
		step(15'h0003, 15'h0004, 20'h0, 5'h01, 5'h01, 3'h1);
		`CHK("micro", 1'b0, uop_micro_fused_out[0])
		`CHK("fus", 2'h2, uop_fused_cnt_out[1:0])
		step(15'h0004, 15'h0005, 20'h0, 5'h01, 5'h01, 3'h1);
		`CHK("micro", 1'b0, uop_micro_fused_out[0])
		`CHK("fus", 2'h2, uop_fused_cnt_out[1:0])
	endtask
	task t_stall;
		logic [3:0] held;
		logic       rdy;
		t_walk;
		held = 4'hf;
		@(posedge mclk_in);
		slow <= 1'b1;
		inst_class_in <= 15'h0000;
		for (int i = 1; i < 5; i++) begin
			@(posedge mclk_in);
			inst_valid_in <= 5'h1f >> (5 - i);
			#1;
			`CHK("hold", held, uop_valid_out)
			rdy = uop_ready_in;
			`CHK("take", rdy ? i[2:0] : 3'h0, take_count_out)
			if (rdy)
				held = 4'hf >> (4 - i);
		end
		@(posedge mclk_in);
		slow <= 1'b0;
		#1;
		`CHK("hold", held, uop_valid_out)
	endtask
	initial begin
		repeat (16) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		#1;
		`CHK("rst", 4'h0, uop_valid_out)
		t_walk;
		t_cc;
		t_no_pair;
		t_micro;
		t_iprel;
		t_stall;
		print_verdict;
	end
endmodule // test_instruction_fusion_decoder
